/* File: rtl/wdr_defines.svh */
// Offsets, field positions, reset values and timing counts of the
// watchdog and reset-source block. Assumes a 100 MHz core clock.
`ifndef WDR_DEFINES_SVH
`define WDR_DEFINES_SVH

// Register byte offsets
`define WDR_OFS_CTRL     8'h00
`define WDR_OFS_RELOAD   8'h04
`define WDR_OFS_CMD      8'h08
`define WDR_OFS_COUNT    8'h0C
`define WDR_OFS_SYSCFG   8'h10
`define WDR_OFS_IRQ_STAT 8'h14
`define WDR_OFS_IRQ_MASK 8'h18

// Control register fields
`define WDR_CTRL_PRESC 0
`define WDR_CTRL_RUN   1
`define WDR_CTRL_SW_FLAG 2
`define WDR_CTRL_WD_FLAG 3
`define WDR_CTRL_SHORT_FLAG 4
`define WDR_CTRL_LONG_FLAG 5
`define WDR_CTRL_PON_FLAG 6

// Command register bits (write only)
`define WDR_CMD_SERVICE 0
`define WDR_CMD_END_INIT 1
`define WDR_CMD_DISABLE 2
`define WDR_CMD_SWRST   3

// Interrupt status bits
`define WDR_IRQ_OVF 0
`define WDR_IRQ_HW  1

// Reset values
`define WDR_RST_RELOAD 8'h00
`define WDR_RST_FLAGS  5'h10

// Timing
`define WDR_CLK_NS    10
`define WDR_HALF_CPU_NS 5
`define WDR_FILTER_NS 500
`define WDR_SHORT_NS ((4*`WDR_HALF_CPU_NS > `WDR_FILTER_NS) ? \
  4*`WDR_HALF_CPU_NS : `WDR_FILTER_NS)
`define WDR_LONG_NS ((1032 + 12)*`WDR_HALF_CPU_NS + `WDR_SHORT_NS)
`define WDR_SEQ_NS (1024*`WDR_HALF_CPU_NS)
`define WDR_SHORT_CYC \
  ((`WDR_SHORT_NS + `WDR_CLK_NS - 1)/`WDR_CLK_NS)
`define WDR_LONG_CYC ((`WDR_LONG_NS + `WDR_CLK_NS - 1)/`WDR_CLK_NS)
`define WDR_SEQ_CYC ((`WDR_SEQ_NS + `WDR_CLK_NS - 1)/`WDR_CLK_NS)
`define WDR_DIV_FAST 2
`define WDR_DIV_SLOW 128

`endif

/* File: rtl/wdr_pkg.sv */
// Types shared by the watchdog and reset-source block.
// Assumes nothing of its surroundings.
package wdr_pkg;
  typedef enum logic [1:0] {
    WDR_RUN,
    WDR_HWRST,
    WDR_SEQ
  } wdr_state_t;
endpackage

/* File: rtl/wdr_top.sv */
// Watchdog timer, reset-source flags and reset input handling.
// Assumes inputs synchronous to core_clk_i and a plain register port.
`include "wdr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wdr_top
  import wdr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic reset_in_n_i,
  output logic reset_in_o,
  output logic reset_in_oe_o,
  input wire logic reset_mode_pin_i,
  output logic reset_out_n_o,
  output logic irq_o
);

  wdr_state_t state;
  logic [15:0] wd_cnt;
  logic [6:0] presc;
  logic [7:0] reload_byte;
  logic prescale_select;
  logic wdog_en;
  logic init_done;
  logic bidir_reset_enable;
  logic [9:0] low_cnt;
  logic [9:0] seq_cnt;
  logic sw_reset_flag;
  logic wdog_reset_flag;
  logic short_hw_reset_flag;
  logic long_hw_reset_flag;
  logic poweron_flag;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;

  logic run;
  logic cmd_wr;
  logic tick;
  logic wd_ovf;
  logic sw_req;
  logic service;
  logic end_init;
  logic hw_seen;
  logic hw_done;
  logic [1:0] irq_set;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////////
  // Decode

  assign run = (state == WDR_RUN);
  assign cmd_wr = wr_i && (addr_i == `WDR_OFS_CMD) && run;
  assign service = cmd_wr && wdata_i[`WDR_CMD_SERVICE];
  assign end_init = cmd_wr && wdata_i[`WDR_CMD_END_INIT];
  assign sw_req = cmd_wr && wdata_i[`WDR_CMD_SWRST];
  // Prescaler ticks every 2 or every 128 core clocks
  assign tick = prescale_select ? (presc == 7'h7F) : presc[0];
  assign wd_ovf = run && wdog_en && tick && (wd_cnt == 16'hFFFF);
  // Own pin drive must not be mistaken for an external reset
  assign hw_seen = run && !reset_in_n_i &&
                   (low_cnt >= 10'(`WDR_SHORT_CYC - 1));
  assign hw_done = (state == WDR_HWRST) && reset_in_n_i;
  assign irq_set = {hw_done, wd_ovf};

  ////////////////////////////////////////////////////////////////////
  // Reset sequencer

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= WDR_RUN;
      seq_cnt <= 10'h000;
    end else begin
      unique case (state)
        WDR_RUN: begin
          if (hw_seen) begin
            state <= WDR_HWRST;
          end else if (wd_ovf || sw_req) begin
            state <= WDR_SEQ;
            seq_cnt <= 10'(`WDR_SEQ_CYC);
          end
        end
        WDR_HWRST: begin
          if (reset_in_n_i) begin
            state <= WDR_SEQ;
            seq_cnt <= 10'(`WDR_SEQ_CYC);
          end
        end
        WDR_SEQ: begin
          seq_cnt <= seq_cnt - 10'h001;
          if (seq_cnt == 10'h001) begin
            state <= WDR_RUN;
          end
        end
      endcase
    end
  end

  // Low time of the reset input, saturating
  always_ff @(posedge core_clk_i) begin
    if (reset_i || reset_in_n_i || state == WDR_SEQ) begin
      low_cnt <= 10'h000;
    end else if (low_cnt != 10'h3FF) begin
      low_cnt <= low_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Watchdog counter

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !run) begin
      presc <= 7'h00;
      wd_cnt <= 16'h0000;
    end else begin
      presc <= presc + 7'h01;
      if (service) begin
        wd_cnt <= {reload_byte, 8'h00};
      end else if (wdog_en && tick) begin
        wd_cnt <= wd_cnt + 16'h0001;
      end
    end
  end

  // Enable and initialisation lock; internal reset restores both
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !run) begin
      wdog_en <= 1'b1;
      init_done <= 1'b0;
    end else begin
      if (end_init) begin
        init_done <= 1'b1;
      end
      if (cmd_wr && wdata_i[`WDR_CMD_DISABLE] && !init_done) begin
        wdog_en <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software-written configuration

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !run) begin
      prescale_select <= 1'b0;
      reload_byte <= `WDR_RST_RELOAD;
    end else if (wr_i) begin
      // Software should rewrite control before each service
      if (addr_i == `WDR_OFS_CTRL) begin
        prescale_select <= wdata_i[`WDR_CTRL_PRESC];
      end
      if (addr_i == `WDR_OFS_RELOAD) begin
        reload_byte <= wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bidir_reset_enable <= 1'b0;
    end else if (state == WDR_SEQ && seq_cnt == 10'h001) begin
      bidir_reset_enable <= 1'b0;
    end else if (run && wr_i && addr_i == `WDR_OFS_SYSCFG) begin
      bidir_reset_enable <= wdata_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset-source flags; a new cause wins over end-init

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      {poweron_flag, long_hw_reset_flag, short_hw_reset_flag,
       wdog_reset_flag, sw_reset_flag} <= `WDR_RST_FLAGS;
    end else if (run && (wd_ovf || sw_req)) begin
      // Prior causes are replaced by the new one
      {poweron_flag, long_hw_reset_flag, short_hw_reset_flag} <= 3'b000;
      wdog_reset_flag <= wd_ovf;
      sw_reset_flag <= sw_req && !wd_ovf;
    end else if (hw_done) begin
      poweron_flag <= 1'b0;
      wdog_reset_flag <= 1'b0;
      sw_reset_flag <= 1'b0;
      // Low mode pin means asynchronous reset with no source flag
      short_hw_reset_flag <= reset_mode_pin_i;
      long_hw_reset_flag <= reset_mode_pin_i &&
                            (low_cnt > 10'(`WDR_LONG_CYC));
    end else if (end_init) begin
      {poweron_flag, long_hw_reset_flag, short_hw_reset_flag,
       wdog_reset_flag, sw_reset_flag} <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, set wins

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      if (wr_i && addr_i == `WDR_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wdata_i[1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      if (wr_i && addr_i == `WDR_OFS_IRQ_MASK) begin
        irq_mask <= wdata_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins and read port

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reset_out_n_o <= 1'b1;
      reset_in_o <= 1'b0;
      reset_in_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      reset_out_n_o <= run && !wd_ovf && !sw_req && !hw_seen;
      reset_in_o <= 1'b0;
      // Low mode pin inhibits driving the reset input
      reset_in_oe_o <= (state == WDR_SEQ) && bidir_reset_enable &&
                       reset_mode_pin_i;
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr_i)
      `WDR_OFS_CTRL: begin
        next_rdata[`WDR_CTRL_PRESC] = prescale_select;
        next_rdata[`WDR_CTRL_RUN] = wdog_en;
        next_rdata[`WDR_CTRL_SW_FLAG] = sw_reset_flag;
        next_rdata[`WDR_CTRL_WD_FLAG] = wdog_reset_flag;
        next_rdata[`WDR_CTRL_SHORT_FLAG] = short_hw_reset_flag;
        next_rdata[`WDR_CTRL_LONG_FLAG] = long_hw_reset_flag;
        next_rdata[`WDR_CTRL_PON_FLAG] = poweron_flag;
      end
      `WDR_OFS_RELOAD: next_rdata[7:0] = reload_byte;
      `WDR_OFS_COUNT: next_rdata[15:0] = wd_cnt;
      `WDR_OFS_SYSCFG: next_rdata[0] = bidir_reset_enable;
      `WDR_OFS_IRQ_STAT: next_rdata[1:0] = irq_stat;
      `WDR_OFS_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_overflow_seq: assert property (@(posedge core_clk_i)
    disable iff (reset_i) wd_ovf && !hw_seen |=> state == WDR_SEQ
    ##1 !reset_out_n_o) else $error("overflow gave no reset sequence");

  a_lock_enable: assert property (@(posedge core_clk_i)
    disable iff (reset_i) run && init_done && wdog_en |=> wdog_en)
    else $error("watchdog disabled after end of init");

  a_service_load: assert property (@(posedge core_clk_i)
    disable iff (reset_i) service && !wd_ovf |=>
    wd_cnt == {$past(reload_byte), 8'h00})
    else $error("service did not reload counter");

  a_count_rate: assert property (@(posedge core_clk_i)
    disable iff (reset_i) run && wdog_en && !prescale_select &&
    !wr_i && !hw_seen && $past(run) && !wd_ovf |=> ##1
    wd_cnt != $past(wd_cnt, 2) || $past(service))
    else $error("divide by two count stalled");

  a_end_init_clr: assert property (@(posedge core_clk_i)
    disable iff (reset_i) end_init && !wd_ovf && !sw_req |=>
    !sw_reset_flag && !wdog_reset_flag && !poweron_flag)
    else $error("end of init left flags set");

  a_swr_flag: assert property (@(posedge core_clk_i)
    disable iff (reset_i) sw_req && !wd_ovf |=>
    sw_reset_flag && !wdog_reset_flag)
    else $error("software reset flag not set");

  a_long_flag: assert property (@(posedge core_clk_i)
    disable iff (reset_i) hw_done && reset_mode_pin_i &&
    low_cnt > 10'(`WDR_LONG_CYC) |=> long_hw_reset_flag &&
    short_hw_reset_flag)
    else $error("long reset not flagged");

  a_spike_reject: assert property (@(posedge core_clk_i)
    disable iff (reset_i) run && !wd_ovf && !sw_req &&
    low_cnt < 10'(`WDR_SHORT_CYC - 1) |=> state == WDR_RUN)
    else $error("short spike accepted as reset");

  a_bidir_clear: assert property (@(posedge core_clk_i)
    disable iff (reset_i) state == WDR_SEQ && seq_cnt == 10'h001 |=>
    !bidir_reset_enable ##1 !reset_in_oe_o)
    else $error("bidir enable kept after sequence");

  a_pin_inhibit: assert property (@(posedge core_clk_i)
    disable iff (reset_i) !reset_mode_pin_i || !bidir_reset_enable |=>
    !reset_in_oe_o)
    else $error("reset input driven while inhibited");

endmodule

`default_nettype wire

/* File: bench/wdr_ext_rst.sv */
// Model of the external reset circuit on the reset input line.
// Assumes the bench pulses start_i for one cycle with low_cyc_i set.
`timescale 1ns/1ps
`default_nettype none
module wdr_ext_rst (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [15:0] low_cyc_i,
  input wire logic oe_i,
  output logic pin_n_o
);
  logic [15:0] left = 16'h0000;
  always @(posedge clk_i) begin
    if (start_i) begin
      left <= low_cyc_i;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  // Pull-up holds the line high unless a party drives it low
  assign pin_n_o = !(oe_i || (left != 16'h0000));
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the watchdog and reset-source block.
// Assumes the design's register map and a 100 MHz clock.
`include "wdr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wdr_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic mode = 1'b1;
  logic start = 1'b0;
  logic [15:0] low_cyc = 16'h0000;
  logic [31:0] rdata_o;
  logic pin_n;
  logic oe;
  logic pin_val;
  logic out_n;
  logic irq_o;
  logic [31:0] d;
  int n;
  int err_total = 0;
  int total_checks = 0;
  logic [16:0] tab [4] = '{17'h1_003c, 17'h1_0258, 17'h0_003c, 17'h1_0004};
  logic [31:0] exp_tab [4] = '{32'h12, 32'h32, 32'h02, 32'h02};

  always #5 core_clk_i = ~core_clk_i;

  wdr_top u_wdr_top (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .reset_in_n_i(pin_n),
    .reset_in_o(pin_val),
    .reset_in_oe_o(oe),
    .reset_mode_pin_i(mode),
    .reset_out_n_o(out_n),
    .irq_o(irq_o)
  );

  wdr_ext_rst u_wdr_ext_rst (
    .clk_i(core_clk_i),
    .start_i(start),
    .low_cyc_i(low_cyc),
    .oe_i(oe),
    .pin_n_o(pin_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi);
    chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Bounded wait for the reset output to reach a level
  task automatic wait_out(input logic lvl, input int m);
    n = 0;
    // Step off the edge so a level launched there is already settled
    #1;
    while (out_n !== lvl && n < m) begin
      @(posedge core_clk_i);
      #1 n++;
    end
  endtask

  // Control is rewritten before every service as software should
  task automatic svc(input logic [31:0] ctrl);
    wr(`WDR_OFS_CTRL, ctrl);
    wr(`WDR_OFS_CMD, 32'h0000_0001);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(`WDR_OFS_CTRL);
    chk("ctrl_por", d, 32'h0000_0042);
    rd(8'h1C);
    chk("unmapped", d, 32'h0000_0000);
    wr(`WDR_OFS_RELOAD, 32'h0000_00FF);
    svc(32'h0000_0000);
    wr(`WDR_OFS_CMD, 32'h0000_0004);
    rd(`WDR_OFS_CTRL);
    chk("ctrl_dis", d, 32'h0000_0040);
    repeat (1000) @(posedge core_clk_i);
    chk("no_ovf", {31'h0, out_n}, 32'h1);
    $display("test disable done");
    for (int i = 1; i >= 0; i--) begin
      wr(`WDR_OFS_SYSCFG, 32'h0000_0001);
      mode <= i[0];
      wr(`WDR_OFS_CMD, 32'h0000_0008);
      wait_out(1'b0, 10);
      rng("sw_out", 0, 3);
      repeat (3) @(posedge core_clk_i);
      chk("pin_drv", {31'h0, oe}, {31'h0, i[0]});
      chk("pin_val", {31'h0, pin_val}, 32'h0);
      wait_out(1'b1, 600);
      rng("seq_len", 505, 513);
      rd(`WDR_OFS_CTRL);
      chk("ctrl_sw", d, 32'h0000_0006);
      rd(`WDR_OFS_SYSCFG);
      chk("bidir_clr", d, 32'h0000_0000);
    end
    $display("test software reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      mode <= tab[i][16];
      low_cyc <= tab[i][15:0];
      start <= 1'b1;
      @(posedge core_clk_i);
      start <= 1'b0;
      wait_out(1'b0, 700);
      chk("hw_seen", {31'h0, n < 700},
          {31'h0, tab[i][15:0] >= `WDR_SHORT_CYC});
      wait_out(1'b1, 1300);
      chk("no_spike", {31'h0, out_n}, 32'h1);
      rd(`WDR_OFS_CTRL);
      chk("ctrl_hw", d, exp_tab[i]);
    end
    $display("test hardware reset done");
    wr(`WDR_OFS_RELOAD, 32'h0000_00FF);
    svc(32'h0000_0000);
    rd(`WDR_OFS_COUNT);
    chk("count_svc", {17'h0, d[15:1]}, 32'h0000_7F80);
    wait_out(1'b0, 600);
    rng("tmo_fast", 507, 513);
    wait_out(1'b1, 600);
    rd(`WDR_OFS_CTRL);
    chk("ctrl_wd", d, 32'h0000_000A);
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    wr(`WDR_OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge core_clk_i);
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    wr(`WDR_OFS_IRQ_STAT, 32'h0000_0003);
    repeat (2) @(posedge core_clk_i);
    chk("irq_off", {31'h0, irq_o}, 32'h0);
    rd(`WDR_OFS_IRQ_STAT);
    chk("stat_clr", d, 32'h0000_0000);
    $display("test fast timeout done");
    wr(`WDR_OFS_CMD, 32'h0000_0002);
    rd(`WDR_OFS_CTRL);
    chk("ctrl_end_init", d, 32'h0000_0002);
    wr(`WDR_OFS_CMD, 32'h0000_0004);
    wr(`WDR_OFS_RELOAD, 32'h0000_00FF);
    svc(32'h0000_0001);
    rd(`WDR_OFS_CTRL);
    chk("ctrl_lock", d, 32'h0000_0003);
    wait_out(1'b0, 33000);
    rng("tmo_slow", 32630, 32770);
    wait_out(1'b1, 600);
    rd(`WDR_OFS_CTRL);
    chk("ctrl_wd2", d, 32'h0000_000A);
    $display("test slow timeout done");
    give_verdict();
  end

  initial begin
    #600_000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
